//--- hdl/sar_adc_control.v
// apb register file, sequencing and interrupt logic of the sar converter
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
`include "sar_adc_control_defs.vh"

module sar_adc_control #(
  parameter RESULT_BITS = `RESULT_BITS
) (
  input wire clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire comp_high,
  output wire [RESULT_BITS-1:0] dac_code,
  output reg sample_enable,
  output wire [1:0] input_channel_select,
  output wire reference_source_select,
  output wire converter_power_on,
  output wire [3:0] analog_pin_select,
  output reg irq
);

  // ****************************************
  // states
  // ****************************************
  localparam [1:0] ST_ACQUIRE = 2'b00;
  localparam [1:0] ST_CONVERT = 2'b01;
  localparam [1:0] ST_RECOVER = 2'b10;

  // ****************************************
  // declarations
  // ****************************************
  reg [7:0] control;
  reg [7:0] pin_clock;
  reg [`IRQ_BITS-1:0] irq_status;
  reg [`IRQ_BITS-1:0] irq_mask;
  reg [1:0] state;
  reg [1:0] recover_count;
  reg [7:0] read_value;
  reg mapped;
  reg [`IRQ_BITS-1:0] next_status;

  wire access;
  wire wr;
  wire [9:0] index;
  wire wr_control;
  wire start;
  wire abort;
  wire tick;
  wire busy;
  wire done;
  wire run;
  wire [RESULT_BITS-1:0] result;
  wire [`IRQ_BITS-1:0] events;

  // ****************************************
  // apb decode
  // ****************************************
  // the access phase always lasts two cycles: pready comes from a flop
  assign access = psel && penable && pready;
  assign wr = access && pwrite;
  assign index = paddr[11:2];
  assign wr_control = wr && (index == `IDX_CONTROL);

  // ****************************************
  // start and abort
  // ****************************************
  // a start in the same write that powers up is ignored,
  // so the sample stage always gets an acquisition first
  assign start = wr_control && pwdata[`BIT_GO] && pwdata[`BIT_POWER] &&
                 control[`BIT_POWER] && (state == ST_ACQUIRE);
  assign abort = busy && ((wr_control && !pwdata[`BIT_GO]) ||
                          (wr_control && !pwdata[`BIT_POWER]));

  // ****************************************
  // register outputs
  // ****************************************
  assign input_channel_select = control[`CHAN_HI:`CHAN_LO];
  assign reference_source_select = control[`BIT_REFERENCE];
  assign converter_power_on = control[`BIT_POWER];
  assign analog_pin_select = pin_clock[`PINS_HI:`PINS_LO];

  // ****************************************
  // conversion clock and approximation
  // ****************************************
  assign run = control[`BIT_POWER] && (state != ST_ACQUIRE);

  conv_clock_gen #(
    .CW(8)
  ) u_clock (
    .clk(clk),
    .reset(reset),
    .run(run),
    .clock_select(pin_clock[`CLKSEL_HI:`CLKSEL_LO]),
    .tick(tick)
  );

  sar_core #(
    .N(RESULT_BITS)
  ) u_core (
    .clk(clk),
    .reset(reset),
    .start(start),
    .abort(abort),
    .step(tick),
    .comp_high(comp_high),
    .busy(busy),
    .done(done),
    .trial(dac_code),
    .result(result)
  );

  // ****************************************
  // control registers
  // ****************************************
  always @(posedge clk) begin
    if (reset) begin
      control <= `CONTROL_RESET;
      pin_clock <= `PIN_CLOCK_RESET;
      irq_mask <= `IRQ_RESET;
    end else if (wr) begin
      if (index == `IDX_CONTROL) begin
        // go bit is not stored: it reads back the converter's busy state
        control[`BIT_JUSTIFY] <= pwdata[`BIT_JUSTIFY];
        control[`BIT_REFERENCE] <= pwdata[`BIT_REFERENCE];
        control[`CHAN_HI:`CHAN_LO] <= pwdata[`CHAN_HI:`CHAN_LO];
        control[`BIT_POWER] <= pwdata[`BIT_POWER];
      end
      if (index == `IDX_PIN_CLOCK) begin
        pin_clock[`CLKSEL_HI:`CLKSEL_LO] <= pwdata[`CLKSEL_HI:`CLKSEL_LO];
        pin_clock[`PINS_HI:`PINS_LO] <= pwdata[`PINS_HI:`PINS_LO];
      end
      if (index == `IDX_IRQ_MASK) begin
        irq_mask <= pwdata[`IRQ_BITS-1:0];
      end
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always @(posedge clk) begin
    if (reset) begin
      state <= ST_ACQUIRE;
      recover_count <= 2'd0;
      sample_enable <= 1'b0;
    end else begin
      case (state)
        ST_ACQUIRE: begin
          recover_count <= 2'd0;
          if (start) begin
            state <= ST_CONVERT;
            sample_enable <= 1'b0;
          end else begin
            // hold switch closed on the selected channel while powered
            sample_enable <= control[`BIT_POWER];
          end
        end
        ST_CONVERT: begin
          sample_enable <= 1'b0;
          recover_count <= 2'd0;
          if (abort || done) begin
            state <= ST_RECOVER;
          end
        end
        ST_RECOVER: begin
          sample_enable <= 1'b0;
          if (!control[`BIT_POWER]) begin
            state <= ST_ACQUIRE;
          end else if (tick) begin
            if (recover_count == `RECOVER_TADS - 2'd1) begin
              // acquisition resumes by itself after the gap
              state <= ST_ACQUIRE;
              recover_count <= 2'd0;
            end else begin
              recover_count <= recover_count + 2'd1;
            end
          end
        end
        default: begin
          state <= ST_ACQUIRE;
          recover_count <= 2'd0;
          sample_enable <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // interrupt status
  // ****************************************
  assign events = {abort, done};

  // a new event wins over a same-cycle write-one-to-clear
  always @* begin
    next_status = irq_status;
    if (wr && (index == `IDX_IRQ_STATUS)) begin
      next_status = irq_status & ~pwdata[`IRQ_BITS-1:0];
    end
    next_status = next_status | events;
  end

  always @(posedge clk) begin
    if (reset) begin
      irq_status <= `IRQ_RESET;
      irq <= 1'b0;
    end else begin
      irq_status <= next_status;
      irq <= |(next_status & irq_mask);
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  always @* begin
    read_value = 8'h00;
    mapped = 1'b1;
    case (index)
      `IDX_CONTROL: begin
        read_value = control;
        read_value[`BIT_GO] = busy;
      end
      `IDX_PIN_CLOCK: begin
        read_value = pin_clock;
      end
      `IDX_RESULT_HIGH: begin
        if (control[`BIT_JUSTIFY]) begin
          read_value = {6'h00, result[9:8]};
        end else begin
          read_value = result[9:2];
        end
      end
      `IDX_RESULT_LOW: begin
        if (control[`BIT_JUSTIFY]) begin
          read_value = result[7:0];
        end else begin
          read_value = {result[1:0], 6'h00};
        end
      end
      `IDX_IRQ_STATUS: begin
        read_value = {6'h00, irq_status};
      end
      `IDX_IRQ_MASK: begin
        read_value = {6'h00, irq_mask};
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // ****************************************
  // apb answer
  // ****************************************
  always @(posedge clk) begin
    if (reset) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !mapped;
      prdata <= pwrite ? 32'h00000000 : {24'h000000, read_value};
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
  end

endmodule // sar_adc_control

//--- hdl/sar_adc_control_defs.vh
// register indices, field positions, reset values and timing for the converter control
`ifndef SAR_ADC_CONTROL_DEFS_VH
`define SAR_ADC_CONTROL_DEFS_VH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define IDX_CONTROL 10'h01f
`define IDX_PIN_CLOCK 10'h020
`define IDX_RESULT_HIGH 10'h021
`define IDX_RESULT_LOW 10'h022
`define IDX_IRQ_STATUS 10'h023
`define IDX_IRQ_MASK 10'h024

// ****************************************
// converter_control fields
// ****************************************
`define BIT_JUSTIFY 7
`define BIT_REFERENCE 6
`define CHAN_HI 3
`define CHAN_LO 2
`define BIT_GO 1
`define BIT_POWER 0
`define CONTROL_RESET 8'h00

// ****************************************
// analog_pin_and_clock_select fields
// ****************************************
`define CLKSEL_HI 6
`define CLKSEL_LO 4
`define PINS_HI 3
`define PINS_LO 0
`define PIN_CLOCK_RESET 8'h0f
`define RC_CLKSEL 2'b11

// ****************************************
// interrupt status and mask
// ****************************************
`define IRQ_DONE 0
`define IRQ_ABORT 1
`define IRQ_BITS 2
`define IRQ_RESET 2'b00

// ****************************************
// result and timing
// ****************************************
`define RESULT_BITS 10
`define CONVERT_TADS 4'd11
`define RECOVER_TADS 2'd2
`define CLK_KHZ 25000
`define RC_MAX_KHZ 500
`define MIN_TAD_NS 1600

`endif

//--- hdl/conv_clock_gen.v
// conversion clock tick generator: prescaled system clock or internal rc clock
`timescale 1ns/100ps
`include "sar_adc_control_defs.vh"

module conv_clock_gen #(
  parameter CW = 8
) (
  input wire clk,
  input wire reset,
  input wire run,
  input wire [2:0] clock_select,
  output reg tick
);
  // rounding the divisor up keeps the rc clock at or below its ceiling
  localparam integer RC_DIV = (`CLK_KHZ + `RC_MAX_KHZ - 1) / `RC_MAX_KHZ;

  reg [CW-1:0] count;
  wire [2:0] shift;
  wire [CW-1:0] divisor;

  // code {s1,s0,s2} + 1 gives the power of two: 000->2, 100->4 ... 110->64
  assign shift = {clock_select[1:0], clock_select[2]} + 3'd1;
  assign divisor = (clock_select[1:0] == `RC_CLKSEL) ? RC_DIV[CW-1:0] :
                   ({{(CW-1){1'b0}}, 1'b1} << shift);

  always @(posedge clk) begin
    if (reset || !run) begin
      count <= {CW{1'b0}};
      tick <= 1'b0;
    end else if (count >= divisor - {{(CW-1){1'b0}}, 1'b1}) begin
      count <= {CW{1'b0}};
      tick <= 1'b1;
    end else begin
      count <= count + {{(CW-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end
endmodule // conv_clock_gen

//--- hdl/sar_core.v
// successive approximation register: one trial bit per conversion clock period
`timescale 1ns/100ps
`include "sar_adc_control_defs.vh"

module sar_core #(
  parameter N = `RESULT_BITS
) (
  input wire clk,
  input wire reset,
  input wire start,
  input wire abort,
  input wire step,
  input wire comp_high,
  output reg busy,
  output reg done,
  output reg [N-1:0] trial,
  output reg [N-1:0] result
);
  reg [3:0] steps;
  reg [N-1:0] probe;

  always @(posedge clk) begin
    if (reset) begin
      busy <= 1'b0;
      done <= 1'b0;
      trial <= {N{1'b0}};
      result <= {N{1'b0}};
      steps <= 4'd0;
      probe <= {N{1'b0}};
    end else begin
      done <= 1'b0;
      if (abort) begin
        // result untouched: the last complete conversion stays visible
        busy <= 1'b0;
        trial <= {N{1'b0}};
        probe <= {N{1'b0}};
      end else if (start && !busy) begin
        busy <= 1'b1;
        steps <= 4'd0;
        probe <= {1'b1, {(N-1){1'b0}}};
        trial <= {1'b1, {(N-1){1'b0}}};
      end else if (busy && step) begin
        steps <= steps + 4'd1;
        if (probe != {N{1'b0}}) begin
          // keep the trial bit if the input is above the dac level
          trial <= (comp_high ? trial : (trial & ~probe)) | (probe >> 1);
          probe <= probe >> 1;
        end
        if (steps == `CONVERT_TADS - 4'd1) begin
          busy <= 1'b0;
          done <= 1'b1;
          // trial back to zero so the dac is idle while acquiring
          trial <= {N{1'b0}};
          result <= trial;
        end
      end
    end
  end
endmodule // sar_core

//--- tb/sar_adc_control_checker.sv
// port assertions for the converter control block
`timescale 1ns/100ps
// ****************
// checker
// ****************
module sar_adc_control_checker #(
  parameter RESULT_BITS = 10
) (
  input wire clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [RESULT_BITS-1:0] dac_code,
  input wire sample_enable,
  input wire converter_power_on,
  input wire [3:0] analog_pin_select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence conv_end;
    $past(dac_code) != 0 && dac_code == 0;
  endsequence
  sequence hold_low;
    !sample_enable [*2];
  endsequence
  sequence start_go;
    $fell(sample_enable) && converter_power_on;
  endsequence
  sequence powered_off;
    !converter_power_on && !$past(converter_power_on);
  endsequence
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside a reply");
  a_start_msb: assert property (start_go |-> ##[0:1] dac_code == 10'h200)
    else $error("first trial is not the top bit");
  a_dac_idle: assert property (sample_enable |-> dac_code == 0)
    else $error("trial code while acquiring");
  a_recover_gap: assert property (conv_end |-> hold_low)
    else $error("acquisition resumed without recovery");
  a_pins_reset: assert property ($fell(reset) |-> analog_pin_select == 4'hf)
    else $error("analog pins not all analog after reset");
  a_power_idle: assert property (powered_off |-> !sample_enable)
    else $error("hold switch closed while powered off");
endmodule // sar_adc_control_checker

bind sar_adc_control sar_adc_control_checker #(.RESULT_BITS(RESULT_BITS)) chk (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .dac_code(dac_code), .sample_enable(sample_enable),
  .converter_power_on(converter_power_on), .analog_pin_select(analog_pin_select));

//--- tb/analog_front.sv
// analog input pins and sample-and-hold model
`timescale 1ns/100ps
// ****************
// front end
// ****************
module analog_front (
  input wire clk,
  input wire sample_enable,
  input wire [1:0] input_channel_select,
  input wire [9:0] dac_code,
  input wire [39:0] levels,
  output wire comp_high
);
  reg [9:0] held;
  initial held = 10'h0;
  // held value ignores input changes once the switch opens
  always @(posedge clk) begin
    if (sample_enable) begin
      held <= levels[input_channel_select*10 +: 10];
    end
  end
  // pins are only sensed, never driven: their drivers stay high impedance
  assign comp_high = held >= dac_code;
endmodule // analog_front

//--- tb/sar_adc_control_tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s expected %h seen %h", n, e, g); end end
// ****************
// bench
// ****************
module sar_adc_control_tb_top;
  localparam bit [2:0] CS [7] = '{3'b000, 3'b100, 3'b001, 3'b101, 3'b010, 3'b110, 3'b011};
  localparam int DV [7] = '{2, 4, 8, 16, 32, 64, 50};
  reg clk, reset, psel, penable, pwrite, e, j, r;
  reg [11:0] paddr;
  reg [31:0] pwdata, q;
  reg [39:0] levels;
  reg [15:0] s;
  reg [9:0] v;
  reg [1:0] ch;
  wire [31:0] prdata;
  wire pready, pslverr, comp_high, sample_enable, reference_source_select;
  wire converter_power_on, irq;
  wire [9:0] dac_code;
  wire [1:0] input_channel_select;
  wire [3:0] analog_pin_select;
  integer bad_count = 0, checked = 0, i, n;
  sar_adc_control #(.RESULT_BITS(10)) dut (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comp_high(comp_high), .dac_code(dac_code),
    .sample_enable(sample_enable), .input_channel_select(input_channel_select),
    .reference_source_select(reference_source_select),
    .converter_power_on(converter_power_on), .analog_pin_select(analog_pin_select),
    .irq(irq));
  analog_front afe (.clk(clk), .sample_enable(sample_enable),
    .input_channel_select(input_channel_select), .dac_code(dac_code), .levels(levels),
    .comp_high(comp_high));
  function [9:0] sar(input [9:0] x);
    integer b;
    begin
      sar = 10'h0;
      for (b = 9; b >= 0; b--) begin
        sar[b] = 1'b1;
        if (x < sar) sar[b] = 1'b0;
      end
    end
  endfunction
  function [15:0] split(input [9:0] x, input rj);
    split = rj ? {6'h0, x} : {x, 6'h0};
  endfunction
  task apb(input bit w, input [11:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge clk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      // read at the rising edge, before the design's own update lands
      do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) bad_count++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      // let register outputs settle before callers look at them
      @(negedge clk);
    end
  endtask
  task wait_acquire;
    begin
      n = 0;
      while (sample_enable !== 1'b1 && n < 1000) begin @(negedge clk); n++; end
      if (sample_enable !== 1'b1) bad_count++;
    end
  endtask
  task finish_test;
    begin
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #(40 * 60000);
    bad_count++;
    finish_test;
  end
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; levels = 0; reset = 1;
    void'($urandom(32'h4acd));
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    apb(0, 12'h07c, 0); `CHK("control", 32'h0, q)
    apb(0, 12'h080, 0); `CHK("pin_clock", 32'h0f, q)
    apb(0, 12'h040, 0); `CHK("unmapped", 1'b1, e)
    apb(1, 12'h080, 32'h05); `CHK("pins", 4'h5, analog_pin_select)
    // one conversion per clock source, mask toggling, random channel and format
    for (i = 0; i < 7; i++) begin
      levels = 40'({$urandom, $urandom});
      ch = 2'($urandom); j = 1'($urandom); r = 1'($urandom);
      if (i == 0) levels[ch*10 +: 10] = 10'h3ff;
      if (i == 1) levels[ch*10 +: 10] = 10'h000;
      v = levels[ch*10 +: 10];
      s = split(sar(v), j);
      apb(1, 12'h090, {31'h0, i[0]});
      apb(1, 12'h080, {25'h0, CS[i], 4'hf});
      apb(1, 12'h07c, {24'h0, j, r, 2'b00, ch, 2'b01});
      `CHK("channel", ch, input_channel_select)
      `CHK("reference", r, reference_source_select)
      wait_acquire;
      apb(1, 12'h07c, {24'h0, j, r, 2'b00, ch, 2'b11});
      n = 0;
      repeat (2000) begin
        @(negedge clk);
        if (dac_code !== 10'h0) n++;
        else if (n > 0) break;
      end
      // a zero result clears the trial one period before the end
      repeat (DV[i]) @(negedge clk);
      `CHK("conv_time", 1'b1, (n > 9 * DV[i] && n <= 12 * DV[i]))
      apb(0, 12'h07c, 0); `CHK("go_clear", {24'h0, j, r, 2'b00, ch, 2'b01}, q)
      apb(0, 12'h08c, 0); `CHK("done_flag", 32'h1, q)
      `CHK("irq", i[0], irq)
      apb(0, 12'h084, 0); `CHK("res_high", {24'h0, s[15:8]}, q)
      apb(0, 12'h088, 0); `CHK("res_low", {24'h0, s[7:0]}, q)
      apb(1, 12'h08c, 32'h3);
      apb(0, 12'h08c, 0); `CHK("flag_clear", 32'h0, q)
      `CHK("irq_clear", 1'b0, irq)
      wait_acquire;
    end
    // abort in mid-conversion on the rc clock (2 us period) keeps the old result
    apb(1, 12'h07c, {24'h0, j, r, 2'b00, ch, 2'b11});
    apb(0, 12'h07c, 0); `CHK("go_busy", 1'b1, q[1])
    apb(1, 12'h07c, {24'h0, j, r, 2'b00, ch, 2'b01});
    wait_acquire;
    `CHK("reacquire", 1'b1, (n >= 90 && n <= 160))
    apb(0, 12'h08c, 0); `CHK("abort_flag", 32'h2, q)
    apb(0, 12'h084, 0); `CHK("kept_high", {24'h0, s[15:8]}, q)
    apb(0, 12'h088, 0); `CHK("kept_low", {24'h0, s[7:0]}, q)
    apb(1, 12'h07c, 0); `CHK("power_off", 1'b0, converter_power_on)
    repeat (3) @(negedge clk);
    `CHK("hold_open", 1'b0, sample_enable)
    apb(1, 12'h07c, 32'h3);
    apb(0, 12'h07c, 0); `CHK("go_ignored", 32'h1, q)
    finish_test;
  end
endmodule // sar_adc_control_tb_top
